// >>> bsr_pkg.sv
// Package for the bank-one special function register block
package bsr_pkg;

  localparam logic [7:0] BSR_OFS_INDIRECT = 8'h80;
  localparam logic [7:0] BSR_OFS_OPTION = 8'h81;
  localparam logic [7:0] BSR_OFS_PCL = 8'h82;
  localparam logic [7:0] BSR_OFS_FLAGS = 8'h83;
  localparam logic [7:0] BSR_OFS_PTR = 8'h84;
  localparam logic [7:0] BSR_OFS_DIRA = 8'h85;
  localparam logic [7:0] BSR_OFS_DIRB = 8'h86;
  localparam logic [7:0] BSR_OFS_DIRT = 8'h87;
  localparam logic [7:0] BSR_OFS_PC_HIGH_HOLDING = 8'h8a;
  localparam logic [7:0] BSR_OFS_INTCTL = 8'h8b;
  localparam logic [7:0] BSR_OFS_PIE = 8'h8c;
  localparam logic [7:0] BSR_OFS_PWR = 8'h8e;
  localparam logic [7:0] BSR_OFS_PER = 8'h92;
  localparam logic [7:0] BSR_OFS_ANCFG = 8'h9f;
  // Own registers: peripheral flag status and read-only event status
  localparam logic [7:0] BSR_OFS_PFLAGS = 8'ha0;
  localparam logic [7:0] BSR_OFS_EVSTAT = 8'ha4;

  localparam logic [7:0] BSR_RST_OPTION = 8'hff;
  localparam logic [7:0] BSR_RST_DIR = 8'hff;
  localparam logic [7:0] BSR_RST_DIRA = 8'h3f;
  localparam logic [7:0] BSR_RST_DIRT = 8'h05;
  localparam logic [7:0] BSR_RST_PER = 8'hff;
  localparam logic [7:0] BSR_RST_ZERO = 8'h00;
  localparam logic [7:0] BSR_RST_FLAGS = 8'h18;

  localparam logic [7:0] BSR_PIE_MASK = 8'h47;
  localparam logic [7:0] BSR_PC_HIGH_HOLDING_MASK = 8'h1f;
  localparam logic [7:0] BSR_DIRA_MASK = 8'h3f;
  localparam logic [7:0] BSR_DIRT_MASK = 8'h05;
  localparam logic [7:0] BSR_ANCFG_MASK = 8'h07;
  localparam logic [7:0] BSR_FLAGS_WMASK = 8'h27;
  localparam int BSR_PIE_CAPCOMP = 2;
  localparam int BSR_PIE_T2 = 1;
  localparam int BSR_PWR_POR = 1;
  localparam int BSR_PWR_BOR = 0;
  localparam int BSR_INT_PERIPHERAL_IRQ_GATE = 6;

  localparam logic [1:0] BSR_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    BSR_RST_POWERON = 2'h0,
    BSR_RST_BROWNOUT = 2'h1,
    BSR_RST_PIN = 2'h3,
    BSR_RST_WATCHDOG = 2'h2
  } bsr_cause_t;

  typedef struct packed {
    logic [3:0] src;
  } bsr_events_t;

endpackage

// >>> bsr_bank.sv
// Bank-one special function register bank with AHB-Lite slave
// Notes on behaviour
// - The peripheral enable register holds one read/write enable per source, cleared by reset.
// - Enable bit 2 passes the capture/compare interrupt when one and blocks it when zero.
// - Enable bit 1 passes the timer 2 period match interrupt when set and blocks it when clear.
// - Enable bits 7 and 5 to 3 always read zero.
// - No peripheral interrupt reaches the core unless the peripheral gate bit is set.
// - The power register has a flag telling power-on reset from pin or watchdog reset.
// - A second power register flag tells brown-out reset from power-on reset.
// - On power-on reset the brown-out flag reads one when brown-out detection is configured on.
// - The upper counter bits are loaded from a five-bit holding register, not directly.
// - Pointer-port, counter low, flags, pointer, holding and interrupt control are reachable from both banks.
// - Every reset loads all ones into the port direction register.
// - Unimplemented addresses read as zero.
// - The pointer register has no reset term and keeps its value over every reset, power-on included; indirect_pointer_o reads zero while reset is held.
// - The postscaled timer 2 match sets a latched flag in bit 1 whatever its enable; the enable gates only the interrupt.
`timescale 1ns/10ps
`default_nettype none
module bsr_bank
  import bsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] rst_cause_i,
  input wire logic brownout_detect_config_i,
  input wire logic [3:0] periph_event_i,
  input wire logic pc_load_high_i,
  input wire logic [7:0] pc_low_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic periph_irq_o,
  output logic [4:0] pc_high_o,
  output logic [7:0] port_b_dir_o,
  output logic [7:0] indirect_pointer_o
);

  logic [7:0] option_q;
  logic [7:0] pcl_q;
  logic [7:0] flags_q;
  logic [7:0] ptr_q;
  logic [7:0] dira_q;
  logic [7:0] dirb_q;
  logic [7:0] dirt_q;
  logic [7:0] pc_high_holding_q;
  logic [7:0] intctl_q;
  logic [7:0] pie_q;
  logic [1:0] pwr_q;
  logic [7:0] per_q;
  logic [7:0] ancfg_q;
  logic [7:0] pflags_q;
  logic [4:0] pch_q;
  logic [7:0] wofs_q;
  logic wr_q;
  logic [7:0] rofs_q;
  logic rd_q;
  logic [7:0] rdata_d;
  logic [7:0] wdat;
  logic [7:0] lofs;
  logic req;
  logic wr_pie;
  logic wr_pflags;
  logic [7:0] ev_set;
  logic irq_d;
  bsr_events_t ev;
  bsr_cause_t cause;

  assign cause = bsr_cause_t'(rst_cause_i);
  assign ev.src = periph_event_i;
  assign wdat = hwdata_i[7:0];
  // Mirrored registers answer in either bank
  // bank mirror
  assign lofs = {1'b1, haddr_i[8:2]};
  assign req = hsel_i && hready_i && (htrans_i == BSR_HTRANS_NONSEQ);

  // Address phase capture; data comes one cycle later
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      wofs_q <= BSR_RST_ZERO;
      rofs_q <= BSR_RST_ZERO;
    end
    else
    begin
      wr_q <= req && hwrite_i;
      rd_q <= req && !hwrite_i;
      wofs_q <= lofs;
      rofs_q <= lofs;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Read data registered at the address phase
  always_comb
  begin
    rdata_d = BSR_RST_ZERO;
    case (lofs)
      BSR_OFS_INDIRECT: rdata_d = BSR_RST_ZERO;
      BSR_OFS_OPTION: rdata_d = option_q;
      BSR_OFS_PCL: rdata_d = pcl_q;
      BSR_OFS_FLAGS: rdata_d = flags_q;
      BSR_OFS_PTR: rdata_d = ptr_q;
      BSR_OFS_DIRA: rdata_d = dira_q;
      BSR_OFS_DIRB: rdata_d = dirb_q;
      BSR_OFS_DIRT: rdata_d = dirt_q;
      BSR_OFS_PC_HIGH_HOLDING: rdata_d = pc_high_holding_q;
      BSR_OFS_INTCTL: rdata_d = intctl_q;
      BSR_OFS_PIE: rdata_d = pie_q & BSR_PIE_MASK;
      BSR_OFS_PWR: rdata_d = {6'h00, pwr_q};
      BSR_OFS_PER: rdata_d = per_q;
      BSR_OFS_ANCFG: rdata_d = ancfg_q;
      BSR_OFS_PFLAGS: rdata_d = pflags_q;
      BSR_OFS_EVSTAT: rdata_d = {4'h0, ev.src};
      default: rdata_d = BSR_RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      hrdata_o <= 32'h0000_0000;
    end
    else if (req && !hwrite_i)
    begin
      hrdata_o <= {24'h00_0000, rdata_d};
    end
  end

  // Option, period, analog and direction registers
  // directions to input on reset
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      option_q <= BSR_RST_OPTION;
      per_q <= BSR_RST_PER;
      ancfg_q <= BSR_RST_ZERO;
      dira_q <= BSR_RST_DIRA;
      dirb_q <= BSR_RST_DIR;
      dirt_q <= BSR_RST_DIRT;
    end
    else if (wr_q)
    begin
      case (wofs_q)
        BSR_OFS_OPTION: option_q <= wdat;
        BSR_OFS_PER: per_q <= wdat;
        BSR_OFS_ANCFG: ancfg_q <= wdat & BSR_ANCFG_MASK;
        BSR_OFS_DIRA: dira_q <= wdat & BSR_DIRA_MASK;
        BSR_OFS_DIRB: dirb_q <= wdat;
        BSR_OFS_DIRT: dirt_q <= wdat & BSR_DIRT_MASK;
        default: ;
      endcase
    end
  end

  // Counter low byte follows the core unless written
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pcl_q <= BSR_RST_ZERO;
    end
    else if (wr_q && wofs_q == BSR_OFS_PCL)
    begin
      pcl_q <= wdat;
    end
    else
    begin
      pcl_q <= pc_low_i;
    end
  end

  // holding register and upper byte transfer
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pc_high_holding_q <= BSR_RST_ZERO;
      pch_q <= 5'h00;
    end
    else
    begin
      if (wr_q && wofs_q == BSR_OFS_PC_HIGH_HOLDING)
      begin
        pc_high_holding_q <= wdat & BSR_PC_HIGH_HOLDING_MASK;
      end
      if (pc_load_high_i || (wr_q && wofs_q == BSR_OFS_PCL))
      begin
        pch_q <= pc_high_holding_q[4:0];
      end
    end
  end

  // Flags: reserved bank-select bits are kept clear by software
  // reserved bits not forced
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      flags_q <= BSR_RST_FLAGS;
      intctl_q <= BSR_RST_ZERO;
    end
    else if (wr_q)
    begin
      if (wofs_q == BSR_OFS_FLAGS)
      begin
        flags_q <= (flags_q & ~BSR_FLAGS_WMASK) | (wdat & BSR_FLAGS_WMASK) | (wdat & 8'hc0);
      end
      if (wofs_q == BSR_OFS_INTCTL)
      begin
        intctl_q <= wdat;
      end
    end
  end

  // pointer survives reset, no reset term
  always_ff @(posedge clk_i)
  begin
    if (wr_q && wofs_q == BSR_OFS_PTR)
    begin
      ptr_q <= wdat;
    end
  end

  assign wr_pie = wr_q && (wofs_q == BSR_OFS_PIE);
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pie_q <= BSR_RST_ZERO;
    end
    else if (wr_pie)
    begin
      pie_q <= wdat & BSR_PIE_MASK;
    end
  end

  // Reset cause latched while reset is held
  // brown-out flag
  // one on power-on with detection on
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      case (cause)
        BSR_RST_POWERON:
        begin
          pwr_q[BSR_PWR_POR] <= 1'b0;
          pwr_q[BSR_PWR_BOR] <= brownout_detect_config_i;
        end
        BSR_RST_BROWNOUT:
        begin
          pwr_q[BSR_PWR_BOR] <= 1'b0;
        end
        default: ;
      endcase
    end
    else if (wr_q && wofs_q == BSR_OFS_PWR)
    begin
      pwr_q <= wdat[1:0];
    end
  end

  // Peripheral flags: set wins over clear
  // latched match flag
  assign wr_pflags = wr_q && (wofs_q == BSR_OFS_PFLAGS);
  assign ev_set = {1'b0, ev.src[3], 3'b000, ev.src[2:0]};
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pflags_q <= BSR_RST_ZERO;
    end
    else if (wr_pflags)
    begin
      pflags_q <= (wdat & BSR_PIE_MASK) | ev_set;
    end
    else
    begin
      pflags_q <= pflags_q | ev_set;
    end
  end

  assign irq_d = intctl_q[BSR_INT_PERIPHERAL_IRQ_GATE] && |(pflags_q & pie_q & BSR_PIE_MASK);

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      periph_irq_o <= 1'b0;
      pc_high_o <= 5'h00;
      port_b_dir_o <= BSR_RST_DIR;
      indirect_pointer_o <= BSR_RST_ZERO;
    end
    else
    begin
      periph_irq_o <= irq_d;
      pc_high_o <= pch_q;
      port_b_dir_o <= dirb_q;
      indirect_pointer_o <= ptr_q;
    end
  end

endmodule
`default_nettype wire

// >>> bsr_bank_props.sv
// Assertion checker for the bank-one register block
`timescale 1ns/10ps
`default_nettype none
module bsr_bank_props
  import bsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pc_load_high_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic periph_irq_o,
  input wire logic [4:0] pc_high_o,
  input wire logic [7:0] port_b_dir_o
);
  logic ph_q, wr_q, gate_q;
  logic [7:0] adr_q, pie_q, lath_q;
  always_ff @(posedge clk_i)
  begin
    ph_q <= nrst_i && hsel_i && hready_i && htrans_i == BSR_HTRANS_NONSEQ;
    wr_q <= hwrite_i;
    adr_q <= haddr_i[7:0];
  end
  // Shadow copies, since the real registers are hidden
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pie_q <= 8'h00;
      gate_q <= 1'b0;
      lath_q <= 8'h00;
    end
    else if (ph_q && wr_q)
    begin
      if (adr_q == 8'h30) pie_q <= hwdata_i[7:0] & 8'h47;
      if (adr_q == 8'h2c) gate_q <= hwdata_i[6];
      if (adr_q == 8'h28) lath_q <= hwdata_i[7:0] & 8'h1f;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  pie_read_a: assert property (ph_q && !wr_q && adr_q == 8'h30 |-> hrdata_o == {24'h0, pie_q})
    else $error("enable register read wrong");
  gap_zero_a: assert property (ph_q && !wr_q && adr_q inside {8'h20, 8'h24, 8'h34} |-> hrdata_o == 32'h0)
    else $error("hole read not zero");
  lath_read_a: assert property (ph_q && !wr_q && adr_q == 8'h28 |-> hrdata_o == {27'h0, lath_q[4:0]})
    else $error("holding register read wrong");
  // Allows one cycle of slack for a registered gate
  irq_gate_a: assert property (periph_irq_o |-> gate_q || $past(gate_q))
    else $error("interrupt without peripheral gate");
  irq_enable_a: assert property (periph_irq_o |-> (pie_q | $past(pie_q)) != 8'h00)
    else $error("interrupt with all enables off");
  reset_vals_a: assert property ($rose(nrst_i) |-> port_b_dir_o == 8'hff && pc_high_o == 5'h00 && !periph_irq_o)
    else $error("outputs not at reset values");
  // Transfer lands in the internal upper counter register first, then in the registered output
  pc_load_a: assert property (pc_load_high_i |=> ##1 {3'h0, pc_high_o} == $past(lath_q, 2))
    else $error("upper counter not loaded from holding");
  cover property (periph_irq_o);
  cover property (pc_load_high_i);
  cover property ($rose(nrst_i));
endmodule
bind bsr_bank bsr_bank_props u_props (.clk_i(clk_i), .nrst_i(nrst_i), .pc_load_high_i(pc_load_high_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .periph_irq_o(periph_irq_o),
  .pc_high_o(pc_high_o), .port_b_dir_o(port_b_dir_o));
`default_nettype wire

// >>> bsr_bank_tb.sv
// Self-checking bench for the bank-one register block
`timescale 1ns/10ps
`default_nettype none
module bsr_bank_tb
  import bsr_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] rst_cause_i = 2'h0;
  logic brownout_detect_config_i = 1'b1;
  logic [3:0] periph_event_i = 4'h0;
  logic pc_load_high_i = 1'b0;
  logic [7:0] pc_low_i = 8'h00;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, periph_irq_o;
  logic [4:0] pc_high_o;
  logic [7:0] port_b_dir_o, indirect_pointer_o, rdat, v, pv;
  logic [31:0] seed = 32'h74df;
  logic [3:0] cf = 4'b1001;
  logic [7:0] pe [4] = '{8'h01, 8'h03, 8'h02, 8'h02};
  bsr_cause_t cs [4] = '{BSR_RST_POWERON, BSR_RST_PIN, BSR_RST_BROWNOUT, BSR_RST_WATCHDOG};
  int err_count = 0;
  int checked = 0;
  always #2.5 clk_i = ~clk_i;
  bsr_bank DUT (.clk_i, .nrst_i, .rst_cause_i, .brownout_detect_config_i, .periph_event_i, .pc_load_high_i,
    .pc_low_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .periph_irq_o, .pc_high_o, .port_b_dir_o, .indirect_pointer_o);
  // Offsets are register indices, four bytes apart
  function automatic logic [7:0] ba(input logic [7:0] o);
    return {o[5:0], 2'b00};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= BSR_HTRANS_NONSEQ;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rdat = hrdata_o[7:0];
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask
  task automatic rst_dut(input logic [1:0] c, input logic f);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    rst_cause_i <= c;
    brownout_detect_config_i <= f;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
  endtask
  // Irq is registered, so let it settle before looking
  task automatic ev(input logic [3:0] e, input logic l, input logic x);
    @(posedge clk_i);
    periph_event_i <= e;
    pc_load_high_i <= l;
    pc_low_i <= seed[15:8];
    @(posedge clk_i);
    periph_event_i <= 4'h0;
    pc_load_high_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({7'h0, periph_irq_o}, {7'h0, x});
  endtask
  initial
  begin
    rst_dut(2'h0, 1'b1);
    rd(ba(BSR_OFS_PIE), 8'h00);
    rd(ba(BSR_OFS_DIRB), 8'hff);
    rd(ba(BSR_OFS_PC_HIGH_HOLDING), 8'h00);
    rd(8'h20, 8'h00);
    seed = lfsr(seed);
    // Reserved bank-select bits kept clear by software
    v = seed[7:0] & 8'h3f;
    bus(1'b1, ba(BSR_OFS_FLAGS), v);
    rd(ba(BSR_OFS_FLAGS), (BSR_RST_FLAGS & ~BSR_FLAGS_WMASK) | (v & BSR_FLAGS_WMASK));
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'hff : seed[7:0];
      bus(1'b1, ba(BSR_OFS_PIE), v);
      rd(ba(BSR_OFS_PIE), v & 8'h47);
    end
    bus(1'b1, ba(BSR_OFS_PIE), 8'h02);
    ev(4'h2, 1'b0, 1'b0);
    bus(1'b1, ba(BSR_OFS_INTCTL), 8'h40);
    ev(4'h0, 1'b0, 1'b1);
    bus(1'b1, ba(BSR_OFS_PIE), 8'h04);
    ev(4'h0, 1'b0, 1'b0);
    ev(4'h4, 1'b0, 1'b1);
    bus(1'b1, ba(BSR_OFS_PIE), 8'h00);
    ev(4'h0, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      bus(1'b1, ba(BSR_OFS_PC_HIGH_HOLDING), seed[7:0]);
      ev(4'h0, 1'b1, 1'b0);
      chk({3'h0, pc_high_o}, {3'h0, seed[4:0]});
      rd(ba(BSR_OFS_PC_HIGH_HOLDING), seed[7:0] & 8'h1f);
    end
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      pv = seed[7:0];
      bus(1'b1, ba(BSR_OFS_PTR), pv);
      bus(1'b1, ba(BSR_OFS_DIRB), 8'h00);
      rst_dut(cs[i], cf[i]);
      rd(ba(BSR_OFS_PWR), pe[i]);
      rd(ba(BSR_OFS_DIRB), 8'hff);
      chk(port_b_dir_o, BSR_RST_DIR);
      if (i > 0) rd(ba(BSR_OFS_PTR), pv);
      if (i > 0) chk(indirect_pointer_o, pv);
      if (i == 0) bus(1'b1, ba(BSR_OFS_PWR), 8'h03);
    end
    end_sim();
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
